// *** logic/fsp_pkg.sv ***
// Shared constants for the flash suspend / security register command logic
package fsp_pkg;
   // Command codes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_QUAD_PROG = 8'h32;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLK64_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_READ_UID = 8'h4b;
   localparam logic [7:0] OP_SREG_ERASE = 8'h44;
   localparam logic [7:0] OP_SREG_PROG = 8'h42;
   localparam logic [7:0] OP_SREG_READ = 8'h48;
   localparam logic [7:0] OP_SET_PARAMS = 8'hc0;
   localparam logic [7:0] OP_SET_WRAP = 8'h77;
   // Bit counts within a frame
   localparam logic [6:0] BITS_OP = 7'd8;
   localparam logic [6:0] BITS_PARAM = 7'd16;
   localparam logic [6:0] BITS_ADDR = 7'd32;
   localparam logic [6:0] BITS_DATA = 7'd40;
   localparam logic [6:0] BITS_MAX = 7'h7f;
   // Security register geometry
   localparam logic [11:0] SREG_BYTES = 12'd1024;
   localparam logic [11:0] SREG_TOTAL = 12'd3072;
   // Timing, core clock 25 ns
   localparam int CLK_NS = 25;
   localparam int T_SUS_NS = 1000;
   localparam logic [7:0] SUS_CYC = 8'(T_SUS_NS / CLK_NS);
   localparam logic [11:0] ARRAY_CYC = 12'd2000;
   localparam logic [11:0] SREG_CYC = 12'd1100;
   // Read parameter reset values
   localparam logic [1:0] DCLK_FIELD_RST = 2'b00;
   localparam logic [1:0] WRAP_FIELD_RST = 2'b00;
   localparam logic [3:0] DCLK_RST = 4'd4;
   localparam logic [6:0] WRAP_RST = 7'd8;
   // Host side
   localparam logic [3:0] SCK_HALF = 4'd8;
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_TXD = 8'h08;
   localparam logic [7:0] REG_RXD = 8'h0c;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam int CMD_ADDR_BIT = 8;
   localparam int CMD_DUMMY_LSB = 9;
   localparam int CMD_READ_BIT = 11;
   localparam int CMD_LEN_LSB = 12;

   typedef enum logic [1:0] {FSP_JOB_NONE, FSP_JOB_PROG, FSP_JOB_ERASE} fsp_job_t;

   function automatic logic [3:0] fsp_dclk(input logic [1:0] f);
      case (f)
         2'b10: fsp_dclk = 4'd6;
         2'b11: fsp_dclk = 4'd8;
         default: fsp_dclk = 4'd4;
      endcase
   endfunction : fsp_dclk

   function automatic logic [6:0] fsp_wrap(input logic [1:0] f);
      fsp_wrap = 7'd8 << f;
   endfunction : fsp_wrap
endpackage : fsp_pkg

// *** logic/fsp_link_if.sv ***
// Serial link between flash host controller and flash device
`timescale 1ns/1ps
interface fsp_link_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic miso;
   modport dev_mp (input cs_n, input sclk, input mosi, output miso);
   modport host_mp (output cs_n, output sclk, output mosi, input miso);
endinterface : fsp_link_if

// *** logic/fsp_dev.sv ***
// Flash device command logic: suspend/resume, unique ID, security registers, read params
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module fsp_dev
   import fsp_pkg::*;
#(
   parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210 // arbitrary
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   fsp_link_if.dev_mp link,
   input wire logic quad_cmd_mode_i,
   output logic write_in_progress_flag_o,
   output logic write_enable_latch_o,
   output logic [1:0] suspend_flags_o,
   output logic [2:0] secreg_lock_bits_o,
   output logic [3:0] dummy_clocks_o,
   output logic [6:0] wrap_bytes_o,
   output logic op_done_o
);
   typedef struct packed {
      logic cs_s1, cs_s2, cs_s3;
      logic ck_s1, ck_s2, ck_s3;
      logic di_s1, di_s2;
      logic [6:0] bitcnt;
      logic [2:0] ibit;
      logic [2:0] obit;
      logic [7:0] op;
      logic [7:0] sh;
      logic [7:0] dat;
      logic [23:0] addr;
      logic [7:0] tx;
      logic miso;
      logic [9:0] rd_addr;
      logic [9:0] wr_addr;
      logic [3:0] uid_idx;
      logic prog_ok;
      logic write_in_progress_flag;
      logic write_enable_latch;
      logic sus_prog;
      logic sus_erase;
      logic [2:0] lock;
      fsp_job_t arr_kind;
      logic [11:0] arr_cnt;
      logic [7:0] lat_cnt;
      fsp_job_t sec_kind;
      logic [11:0] sec_cnt;
      logic [1:0] sec_sel;
      logic [3:0] dclk;
      logic [6:0] wrap;
      logic done;
   } fsp_dev_st_t;

   fsp_dev_st_t s_r;
   fsp_dev_st_t s_nxt;
   logic [7:0] mem [0:3071];
   logic mem_we;
   logic [11:0] mem_wa;
   logic [7:0] mem_wd;
   logic rise;
   logic fall;
   logic cs_rise;
   logic [7:0] byte_v;
   logic [7:0] out_v;
   logic [23:0] addr_v;
   logic [11:0] rd_idx;

   // Address maps to one of the three registers
   function automatic logic sreg_valid(input logic [23:0] a);
      sreg_valid = (a[23:16] == 8'h00) && (a[15:14] == 2'b00) && (a[13:12] != 2'b00)
         && (a[11:10] == 2'b00);
   endfunction : sreg_valid

   function automatic logic [1:0] sreg_sel(input logic [23:0] a);
      sreg_sel = a[13:12] - 2'd1;
   endfunction : sreg_sel

   // Commands refused while an operation is suspended
   function automatic logic sus_block(input logic [7:0] op, input logic sp, input logic se);
      logic erase_like;
      erase_like = (op == OP_WRITE_STATUS) || (op == OP_SREG_ERASE) || (op == OP_SECTOR_ERASE)
         || (op == OP_BLK32_ERASE) || (op == OP_BLK64_ERASE) || (op == OP_CHIP_ERASE_A)
         || (op == OP_CHIP_ERASE_B);
      sus_block = (se && erase_like)
         || (sp && (erase_like || (op == OP_SREG_PROG) || (op == OP_PAGE_PROG)
         || (op == OP_QUAD_PROG)));
   endfunction : sus_block

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      mem_we = 1'b0;
      mem_wa = 12'h000;
      mem_wd = 8'hff;
      byte_v = {s_r.sh[6:0], s_r.di_s2};
      addr_v = {s_r.addr[22:0], s_r.di_s2};
      out_v = 8'h00;
      rd_idx = {sreg_sel(s_r.addr), s_r.rd_addr};
      s_nxt.cs_s1 = link.cs_n;
      s_nxt.cs_s2 = s_r.cs_s1;
      s_nxt.cs_s3 = s_r.cs_s2;
      s_nxt.ck_s1 = link.sclk;
      s_nxt.ck_s2 = s_r.ck_s1;
      s_nxt.ck_s3 = s_r.ck_s2;
      s_nxt.di_s1 = link.mosi;
      s_nxt.di_s2 = s_r.di_s1;
      rise = s_r.ck_s2 && !s_r.ck_s3 && !s_r.cs_s2;
      fall = !s_r.ck_s2 && s_r.ck_s3 && !s_r.cs_s2;
      cs_rise = s_r.cs_s2 && !s_r.cs_s3;

      // Array engine and suspend latency
      if (s_r.arr_kind != FSP_JOB_NONE && !s_r.sus_prog && !s_r.sus_erase) begin
         if (s_r.arr_cnt == 12'h000) begin
            s_nxt.arr_kind = FSP_JOB_NONE;
            s_nxt.write_in_progress_flag = 1'b0;
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.arr_cnt = s_r.arr_cnt - 12'd1;
         end
      end
      if (s_r.lat_cnt != 8'h00) begin
         s_nxt.lat_cnt = s_r.lat_cnt - 8'd1;
         if (s_r.lat_cnt == 8'd1) begin
            s_nxt.write_in_progress_flag = 1'b0;
         end
      end
      // Security register self-timed cycle; erase sweeps the register to all ones
      if (s_r.sec_kind != FSP_JOB_NONE) begin
         if (s_r.sec_kind == FSP_JOB_ERASE && s_r.sec_cnt < SREG_BYTES) begin
            mem_we = 1'b1;
            mem_wa = {s_r.sec_sel, s_r.sec_cnt[9:0]};
         end
         if (s_r.sec_cnt == 12'h000) begin
            s_nxt.sec_kind = FSP_JOB_NONE;
            s_nxt.write_in_progress_flag = 1'b0;
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.sec_cnt = s_r.sec_cnt - 12'd1;
         end
      end

      // Shift in on rising edges
      if (rise) begin
         s_nxt.sh = byte_v;
         s_nxt.ibit = s_r.ibit + 3'd1;
         if (s_r.bitcnt != BITS_MAX) begin
            s_nxt.bitcnt = s_r.bitcnt + 7'd1;
         end
         if (s_r.bitcnt == BITS_OP - 7'd1) begin
            s_nxt.op = byte_v;
         end
         if (s_r.bitcnt >= BITS_OP && s_r.bitcnt < BITS_ADDR) begin
            s_nxt.addr = addr_v;
         end
         if (s_r.ibit == 3'd7) begin
            s_nxt.dat = byte_v;
            if (s_r.bitcnt == BITS_ADDR - 7'd1) begin
               s_nxt.rd_addr = addr_v[9:0];
               s_nxt.wr_addr = addr_v[9:0];
               s_nxt.prog_ok = s_r.write_enable_latch && !s_r.write_in_progress_flag && s_r.sec_kind == FSP_JOB_NONE
                  && !sus_block(s_r.op, s_r.sus_prog, s_r.sus_erase) && sreg_valid(addr_v)
                  && !s_r.lock[sreg_sel(addr_v)];
            end
            if (s_r.op == OP_SREG_PROG && s_r.bitcnt >= BITS_ADDR + 7'd7 && s_r.prog_ok) begin
               mem_we = 1'b1;
               mem_wa = {sreg_sel(s_r.addr), s_r.wr_addr};
               mem_wd = mem[mem_wa] & byte_v;
               s_nxt.wr_addr = {s_r.wr_addr[9:8], s_r.wr_addr[7:0] + 8'd1};
            end
         end
      end

      // Shift out on falling edges once address and dummy byte are in
      if (fall && s_r.bitcnt >= BITS_DATA) begin
         s_nxt.obit = s_r.obit + 3'd1;
         if (s_r.obit == 3'd0) begin
            if (s_r.op == OP_SREG_READ) begin
               out_v = (sreg_valid(s_r.addr) && rd_idx < SREG_TOTAL) ? mem[rd_idx] : 8'hff;
               s_nxt.rd_addr = s_r.rd_addr + 10'd1;
            end else if (s_r.op == OP_READ_UID) begin
               out_v = UNIQUE_ID[{~s_r.uid_idx, 3'b000} +: 8];
               s_nxt.uid_idx = s_r.uid_idx + 4'd1;
            end
            s_nxt.miso = out_v[7];
            s_nxt.tx = {out_v[6:0], 1'b0};
         end else begin
            s_nxt.miso = s_r.tx[7];
            s_nxt.tx = {s_r.tx[6:0], 1'b0};
         end
      end

      // Commit at the end of a frame
      if (cs_rise) begin
         case (s_r.op)
            OP_WRITE_ENABLE: if (s_r.bitcnt == BITS_OP) s_nxt.write_enable_latch = 1'b1;
            OP_WRITE_DISABLE: if (s_r.bitcnt == BITS_OP) s_nxt.write_enable_latch = 1'b0;
            OP_SUSPEND: begin
               if (s_r.bitcnt == BITS_OP && s_r.write_in_progress_flag && s_nxt.arr_kind != FSP_JOB_NONE
                  && !s_r.sus_prog && !s_r.sus_erase) begin
                  s_nxt.sus_prog = (s_r.arr_kind == FSP_JOB_PROG);
                  s_nxt.sus_erase = (s_r.arr_kind == FSP_JOB_ERASE);
                  s_nxt.lat_cnt = SUS_CYC;
               end
            end
            OP_RESUME: begin
               if (s_r.bitcnt == BITS_OP && (s_r.sus_prog || s_r.sus_erase) && !s_r.write_in_progress_flag) begin
                  s_nxt.sus_prog = 1'b0;
                  s_nxt.sus_erase = 1'b0;
                  s_nxt.write_in_progress_flag = 1'b1;
               end
            end
            OP_SREG_ERASE: begin
               if (s_r.bitcnt == BITS_ADDR && s_r.prog_ok) begin
                  s_nxt.sec_kind = FSP_JOB_ERASE;
                  s_nxt.sec_cnt = SREG_CYC;
                  s_nxt.sec_sel = sreg_sel(s_r.addr);
                  s_nxt.write_in_progress_flag = 1'b1;
                  s_nxt.write_enable_latch = 1'b0;
               end
            end
            OP_SREG_PROG: begin
               if (s_r.bitcnt >= BITS_DATA && s_r.prog_ok) begin
                  s_nxt.sec_kind = FSP_JOB_PROG;
                  s_nxt.sec_cnt = SREG_CYC;
                  s_nxt.write_in_progress_flag = 1'b1;
                  s_nxt.write_enable_latch = 1'b0;
               end
            end
            OP_WRITE_STATUS: begin
               if (s_r.bitcnt == BITS_PARAM && s_r.write_enable_latch && !s_r.write_in_progress_flag
                  && !sus_block(s_r.op, s_r.sus_prog, s_r.sus_erase)) begin
                  s_nxt.lock = s_r.lock | s_r.dat[5:3];
                  s_nxt.write_enable_latch = 1'b0;
               end
            end
            OP_SET_PARAMS: begin
               if (s_r.bitcnt == BITS_PARAM && quad_cmd_mode_i) begin
                  s_nxt.dclk = fsp_dclk(s_r.dat[5:4]);
                  s_nxt.wrap = fsp_wrap(s_r.dat[1:0]);
               end
            end
            OP_SET_WRAP: if (s_r.bitcnt == BITS_DATA) s_nxt.wrap = fsp_wrap(s_r.dat[6:5]);
            OP_PAGE_PROG, OP_QUAD_PROG, OP_SECTOR_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE,
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
               if (s_r.write_enable_latch && !s_r.write_in_progress_flag && s_r.arr_kind == FSP_JOB_NONE
                  && s_r.sec_kind == FSP_JOB_NONE) begin
                  if (s_r.op == OP_PAGE_PROG || s_r.op == OP_QUAD_PROG) begin
                     if (s_r.bitcnt >= BITS_DATA) s_nxt.arr_kind = FSP_JOB_PROG;
                  end else if (s_r.bitcnt == ((s_r.op == OP_CHIP_ERASE_A
                     || s_r.op == OP_CHIP_ERASE_B) ? BITS_OP : BITS_ADDR)) begin
                     s_nxt.arr_kind = FSP_JOB_ERASE;
                  end
                  if (s_nxt.arr_kind != FSP_JOB_NONE) begin
                     s_nxt.arr_cnt = ARRAY_CYC;
                     s_nxt.write_in_progress_flag = 1'b1;
                     s_nxt.write_enable_latch = 1'b0;
                  end
               end
            end
            default: ;
         endcase
      end
      // Wrap and dummy settings are untouched by quad mode changes
      if (s_r.cs_s2) begin
         s_nxt.bitcnt = 7'd0;
         s_nxt.ibit = 3'd0;
         s_nxt.obit = 3'd0;
         s_nxt.uid_idx = 4'd0;
         s_nxt.miso = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.cs_s1 <= 1'b1;
         s_r.cs_s2 <= 1'b1;
         s_r.cs_s3 <= 1'b1;
         s_r.dclk <= DCLK_RST;
         s_r.wrap <= WRAP_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign link.miso = s_r.miso;
   assign write_in_progress_flag_o = s_r.write_in_progress_flag;
   assign write_enable_latch_o = s_r.write_enable_latch;
   assign suspend_flags_o = {s_r.sus_prog, s_r.sus_erase};
   assign secreg_lock_bits_o = s_r.lock;
   assign dummy_clocks_o = s_r.dclk;
   assign wrap_bytes_o = s_r.wrap;
   assign op_done_o = s_r.done;
endmodule : fsp_dev

// *** logic/fsp_host.sv ***
// Flash host controller: APB command registers driving the serial link
`timescale 1ns/1ps
module fsp_host
   import fsp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   fsp_link_if.host_mp link
);
   typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TRAIL, H_GAP} fsp_hst_t;
   typedef struct packed {
      fsp_hst_t st;
      logic [3:0] tmr;
      logic [7:0] b;
      logic [7:0] total;
      logic cs_n;
      logic sclk;
      logic mosi;
      logic [7:0] op;
      logic has_addr;
      logic [1:0] dummy;
      logic rd;
      logic [4:0] len;
      logic [23:0] addr;
      logic [31:0] txd;
      logic [31:0] rxd;
      logic mi_s1;
      logic mi_s2;
      logic ack;
      logic [31:0] rdata;
      logic err;
   } fsp_host_st_t;

   fsp_host_st_t s_r;
   fsp_host_st_t s_nxt;
   logic [7:0] off_d;
   logic [7:0] off_x;
   logic [7:0] nb;
   logic mapped;

   // Bit to send at frame position p: opcode, address, dummy zeros, write data
   function automatic logic bit_at(input fsp_host_st_t s, input logic [7:0] p,
                                   input logic [7:0] od, input logic [7:0] ox);
      logic [7:0] k;
      k = 8'h00;
      if (p < 8'd8) begin
         k = 8'd7 - p;
         bit_at = s.op[k[2:0]];
      end else if (p < od) begin
         k = 8'd31 - p;
         bit_at = s.addr[k[4:0]];
      end else if (p < ox || p >= ox + 8'd32) begin
         bit_at = 1'b0;
      end else begin
         k = 8'd31 - (p - ox);
         bit_at = s.txd[k[4:0]];
      end
   endfunction : bit_at

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      s_nxt.mi_s1 = link.miso;
      s_nxt.mi_s2 = s_r.mi_s1;
      off_d = s_r.has_addr ? 8'd32 : 8'd8;
      off_x = off_d + {3'b000, s_r.dummy, 3'b000};
      nb = s_r.b + 8'd1;
      mapped = (paddr == REG_CMD) || (paddr == REG_ADDR) || (paddr == REG_TXD)
         || (paddr == REG_RXD) || (paddr == REG_STAT);

      // APB: answer one cycle into the access phase, act at the handshake edge
      if (psel && penable && !s_r.ack) begin
         s_nxt.ack = 1'b1;
         s_nxt.err = !mapped;
         case (paddr)
            REG_CMD: s_nxt.rdata = {15'h0000, s_r.len, s_r.rd, s_r.dummy, s_r.has_addr, s_r.op};
            REG_ADDR: s_nxt.rdata = {8'h00, s_r.addr};
            REG_TXD: s_nxt.rdata = s_r.txd;
            REG_RXD: s_nxt.rdata = s_r.rxd;
            REG_STAT: s_nxt.rdata = {31'h00000000, s_r.st != H_IDLE};
            default: s_nxt.rdata = 32'h00000000;
         endcase
      end else if (psel && penable && s_r.ack) begin
         s_nxt.ack = 1'b0;
         if (pwrite && s_r.st == H_IDLE) begin
            case (paddr)
               REG_ADDR: s_nxt.addr = pwdata[23:0];
               REG_TXD: s_nxt.txd = pwdata;
               REG_CMD: begin
                  s_nxt.op = pwdata[7:0];
                  s_nxt.has_addr = pwdata[CMD_ADDR_BIT];
                  s_nxt.dummy = pwdata[CMD_DUMMY_LSB +: 2];
                  s_nxt.rd = pwdata[CMD_READ_BIT];
                  s_nxt.len = pwdata[CMD_LEN_LSB +: 5];
                  s_nxt.total = 8'd8 + (pwdata[CMD_ADDR_BIT] ? 8'd24 : 8'd0)
                     + {3'b000, pwdata[CMD_DUMMY_LSB +: 2], 3'b000}
                     + {pwdata[CMD_LEN_LSB +: 5], 3'b000};
                  s_nxt.b = 8'd0;
                  s_nxt.rxd = 32'h00000000;
                  s_nxt.cs_n = 1'b0;
                  s_nxt.mosi = pwdata[7];
                  s_nxt.tmr = SCK_HALF - 4'd1;
                  s_nxt.st = H_LOW;
               end
               default: ;
            endcase
         end
      end else begin
         s_nxt.ack = 1'b0;
      end

      // Serial engine: mode 0, sample on rise, change on fall
      if (s_r.st != H_IDLE) begin
         s_nxt.tmr = s_r.tmr - 4'd1;
      end
      case (s_r.st)
         H_IDLE: ;
         H_LOW: begin
            if (s_r.tmr == 4'd0) begin
               s_nxt.sclk = 1'b1;
               s_nxt.tmr = SCK_HALF - 4'd1;
               s_nxt.st = H_HIGH;
               if (s_r.rd && s_r.b >= off_x) begin
                  s_nxt.rxd = {s_r.rxd[30:0], s_r.mi_s2};
               end
            end
         end
         H_HIGH: begin
            if (s_r.tmr == 4'd0) begin
               s_nxt.sclk = 1'b0;
               s_nxt.b = nb;
               s_nxt.tmr = SCK_HALF - 4'd1;
               if (nb == s_r.total) begin
                  s_nxt.st = H_TRAIL;
               end else begin
                  s_nxt.mosi = bit_at(s_r, nb, off_d, off_x);
                  s_nxt.st = H_LOW;
               end
            end
         end
         H_TRAIL: begin
            if (s_r.tmr == 4'd0) begin
               s_nxt.cs_n = 1'b1;
               s_nxt.mosi = 1'b0;
               s_nxt.tmr = SCK_HALF - 4'd1;
               s_nxt.st = H_GAP;
            end
         end
         H_GAP: if (s_r.tmr == 4'd0) s_nxt.st = H_IDLE;
         default: s_nxt.st = H_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.cs_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.cs_n = s_r.cs_n;
   assign link.sclk = s_r.sclk;
   assign link.mosi = s_r.mosi;
   assign prdata = s_r.rdata;
   assign pready = s_r.ack;
   assign pslverr = s_r.err & s_r.ack;
endmodule : fsp_host

// *** test/fsp_properties.sv ***
// Checker for the flash link and the device status flags
`timescale 1ns/1ps
module fsp_properties (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic write_in_progress_flag_o,
   input wire logic write_enable_latch_o,
   input wire logic [1:0] suspend_flags_o,
   input wire logic [3:0] dummy_clocks_o,
   input wire logic [6:0] wrap_bytes_o,
   input wire logic op_done_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_sus;
      $rose(|suspend_flags_o);
   endsequence
   sequence s_res;
      $fell(|suspend_flags_o);
   endsequence
   a_idle_clock_low: assert property (cs_n |-> !sclk) else $error("sclk high outside frame");
   a_one_job: assert property (suspend_flags_o != 2'b11) else $error("both suspend flags set");
   a_sus_needs_busy: assert property (s_sus |-> $past(write_in_progress_flag_o))
      else $error("suspend taken while idle");
   a_sus_drops_wip: assert property (s_sus |-> ##[1:42] !write_in_progress_flag_o)
      else $error("busy not cleared after suspend");
   a_res_gate: assert property (s_res |-> !$past(write_in_progress_flag_o))
      else $error("resume taken while busy");
   a_res_sets_wip: assert property (s_res |-> ##[0:8] write_in_progress_flag_o)
      else $error("busy not set after resume");
   a_done_clears: assert property (op_done_o |-> ##[0:1] !write_in_progress_flag_o)
      else $error("busy stays after done");
   a_no_start_sus: assert property ($rose(write_in_progress_flag_o) |-> !(|suspend_flags_o))
      else $error("job started while suspended");
   a_params_legal: assert property (dummy_clocks_o inside {4'h4, 4'h6, 4'h8} &&
      wrap_bytes_o inside {7'h08, 7'h10, 7'h20, 7'h40}) else $error("bad read parameters");
   a_start_drops_wel: assert property ($rose(write_in_progress_flag_o) &&
      !$fell(|suspend_flags_o) |-> !write_enable_latch_o)
      else $error("write enable kept at job start");
endmodule : fsp_properties

// *** test/fsp_tb_top.sv ***
// Self-checking bench: host and device joined over the link
`timescale 1ns/1ps
module flash_suspend_secreg_params_tb_top;
   import fsp_pkg::*;
   localparam logic [127:0] UID = 128'h5a5a_1234_c3c3_8765_0f0f_abcd_9999_4321; // arbitrary
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, quad = 0;
   logic pready, pslverr, write_in_progress_flag, write_enable_latch, done, er;
   logic [7:0] paddr = 8'h00, v;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0] sus;
   logic [2:0] lock;
   logic [3:0] dck, p;
   logic [6:0] wrp;
   int num_errors = 0, samples_checked = 0;
   fsp_link_if lnk();
   fsp_host i_fsp_host(.core_clk_i(clk), .rst_i(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(lnk.host_mp));
   fsp_dev #(.UNIQUE_ID(UID)) i_fsp_dev(.core_clk_i(clk), .rst_i(rst), .link(lnk.dev_mp),
      .quad_cmd_mode_i(quad), .write_in_progress_flag_o(write_in_progress_flag), .write_enable_latch_o(write_enable_latch),
      .suspend_flags_o(sus), .secreg_lock_bits_o(lock), .dummy_clocks_o(dck),
      .wrap_bytes_o(wrp), .op_done_o(done));
   fsp_properties i_fsp_properties(.core_clk_i(clk), .rst_i(rst), .cs_n(lnk.cs_n),
      .sclk(lnk.sclk), .write_in_progress_flag_o(write_in_progress_flag), .write_enable_latch_o(write_enable_latch),
      .suspend_flags_o(sus), .dummy_clocks_o(dck), .wrap_bytes_o(wrp), .op_done_o(done));
   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   // Load address and data, launch the frame, wait for idle, fetch the received word
   task automatic fr(input logic [31:0] c, input logic [23:0] a, input logic [31:0] t);
      apb(1, REG_ADDR, {8'h00, a}); apb(1, REG_TXD, t); apb(1, REG_CMD, c);
      do apb(0, REG_STAT, 32'h0); while (rd[0] !== 1'b0);
      apb(0, REG_RXD, 32'h0);
   endtask : fr
   function automatic logic [31:0] cw(input logic [7:0] op, input logic ad,
      input logic [1:0] dm, input logic r, input logic [4:0] n);
      return {15'h0, n, r, dm, ad, op};
   endfunction : cw
   function automatic logic [3:0] edc(input logic [1:0] f);
      return f == 2'b11 ? 4'h8 : (f == 2'b10 ? 4'h6 : 4'h4);
   endfunction : edc
   task automatic idle;
      while (write_in_progress_flag !== 1'b0) @(posedge clk);
   endtask : idle
   task automatic results;
      if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   initial begin
      #1_000_000;
      num_errors++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h72bc));
      v = 8'($urandom);
      repeat (8) @(posedge clk);
      rst <= 0;
      chk({dck, wrp}, {4'h4, 7'h08});
      apb(0, 8'h20, 32'h0);
      chk(er, 1'b1);
      fr(cw(OP_WRITE_ENABLE, 0, 0, 0, 0), 0, 0);
      fr(cw(OP_SREG_ERASE, 1, 0, 0, 1), 24'h001000, 0);
      chk({write_in_progress_flag, write_enable_latch}, 2'b01);
      fr(cw(OP_SREG_ERASE, 1, 0, 0, 0), 24'h001000, 0);
      chk(write_in_progress_flag, 1'b1);
      idle();
      chk(write_enable_latch, 1'b0);
      fr(cw(OP_WRITE_ENABLE, 0, 0, 0, 0), 0, 0);
      fr(cw(OP_SREG_PROG, 1, 0, 0, 2), 24'h0013ff, {v, ~v, 16'h0});
      idle();
      fr(cw(OP_SREG_READ, 1, 1, 1, 3), 24'h0013fe, 0);
      chk(rd[23:0], {8'hff, v, 8'hff});
      fr(cw(OP_SREG_READ, 1, 1, 1, 1), 24'h001300, 0);
      chk(rd[7:0], {24'h0, ~v});
      fr(cw(OP_WRITE_ENABLE, 0, 0, 0, 0), 0, 0);
      fr(cw(OP_WRITE_STATUS, 0, 0, 0, 1), 0, 32'h0800_0000);
      idle();
      fr(cw(OP_WRITE_ENABLE, 0, 0, 0, 0), 0, 0);
      fr(cw(OP_SREG_ERASE, 1, 0, 0, 0), 24'h001000, 0);
      chk({lock, write_in_progress_flag, write_enable_latch}, 5'b00101);
      fr(cw(OP_READ_UID, 1, 1, 1, 4), 0, 0);
      chk(rd, UID[127:96]);
      for (int i = 0; i < 2; i++) begin
         fr(cw(OP_WRITE_ENABLE, 0, 0, 0, 0), 0, 0);
         fr(cw(i ? OP_PAGE_PROG : OP_SECTOR_ERASE, 1, 0, 0, 5'(i)), 0, 0);
         fr(cw(OP_SUSPEND, 0, 0, 0, 0), 0, 0);
         chk(sus, i ? 2'b10 : 2'b01);
         repeat (41) @(posedge clk);
         chk(write_in_progress_flag, 1'b0);
         fr(cw(OP_WRITE_ENABLE, 0, 0, 0, 0), 0, 0);
         fr(cw(OP_SREG_ERASE, 1, 0, 0, 0), 24'h002000, 0);
         fr(cw(OP_SUSPEND, 0, 0, 0, 0), 0, 0);
         chk({sus, write_in_progress_flag, write_enable_latch}, {i ? 2'b10 : 2'b01, 2'b01});
         fr(cw(OP_RESUME, 0, 0, 0, 0), 0, 0);
         chk({sus, write_in_progress_flag}, 3'b001);
         idle();
         fr(cw(OP_RESUME, 0, 0, 0, 0), 0, 0);
         chk({sus, write_in_progress_flag}, 3'b000);
      end
      quad <= 1;
      repeat (4) begin
         p = 4'($urandom);
         fr(cw(OP_SET_PARAMS, 0, 0, 0, 1), 0, {2'b00, p[3:2], 2'b00, p[1:0], 24'h0});
         chk({dck, wrp}, {edc(p[3:2]), 7'h08 << p[1:0]});
      end
      quad <= 0;
      fr(cw(OP_SET_PARAMS, 0, 0, 0, 1), 0, {2'b00, ~p[3:2], 2'b00, ~p[1:0], 24'h0});
      chk({dck, wrp}, {edc(p[3:2]), 7'h08 << p[1:0]});
      results();
   end
endmodule : flash_suspend_secreg_params_tb_top
